// file: pci_pkg.sv
package pci_pkg;
   localparam int          AD_W        = 32;
   localparam int          BE_W        = 4;
   localparam int          IRQ_N       = 8;
   localparam logic [3:0]  CMD_IO_RD   = 4'h2;
   localparam logic [3:0]  CMD_IO_WR   = 4'h3;
   localparam logic [3:0]  CMD_MEM_RD  = 4'h6;
   localparam logic [3:0]  CMD_MEM_WR  = 4'h7;
   localparam logic [3:0]  CMD_CFG_RD  = 4'ha;
   localparam logic [3:0]  CMD_CFG_WR  = 4'hb;
   localparam logic [31:0] IO_BASE_RST = 32'h0000_0300;
   localparam int          IO_SPAN_LOG = 5;
   localparam logic [7:0]  MASK_RST    = 8'h00;
   localparam logic [5:0]  CFG_IRQ_IDX = 6'h3f;
   localparam logic [5:0]  CFG_MSK_IDX = 6'h3e;
   localparam logic [5:0]  CFG_BAR_IDX = 6'h04;
   localparam int          WAIT_RST    = 1;
endpackage : pci_pkg

// file: pci_link_if.sv
`timescale 1ns/1ps
interface pci_link_if;
   logic [31:0] ad_h;
   logic        ad_h_oe;
   logic [31:0] ad_d;
   logic        ad_d_oe;
   logic [3:0]  cbe_n;
   logic        par_h;
   logic        par_h_oe;
   logic        par_d;
   logic        par_d_oe;
   logic        frame_n;
   logic        irdy_n;
   logic        trdy_n;
   logic        stop_n;
   logic        devsel_n;
   logic        tgt_oe;
   logic        idsel;
   logic        inta_n_o;
   logic        inta_oe;
   // Resolved wire levels; pull-ups assumed when nobody drives
   wire  [31:0] ad       = ad_h_oe ? ad_h : (ad_d_oe ? ad_d : 32'hffff_ffff);
   wire         par      = par_h_oe ? par_h : (par_d_oe ? par_d : 1'b1);
   wire         trdy_w   = tgt_oe ? trdy_n : 1'b1;
   wire         stop_w   = tgt_oe ? stop_n : 1'b1;
   wire         devsel_w = tgt_oe ? devsel_n : 1'b1;
   wire         inta_w   = inta_oe ? inta_n_o : 1'b1;
   modport dev  (input ad, par, cbe_n, frame_n, irdy_n, idsel,
                 output ad_d, ad_d_oe, par_d, par_d_oe, trdy_n, stop_n, devsel_n,
                 tgt_oe, inta_n_o, inta_oe);
   modport host (input ad, par, trdy_w, stop_w, devsel_w, inta_w,
                 output ad_h, ad_h_oe, cbe_n, par_h, par_h_oe, frame_n, irdy_n, idsel);
endinterface : pci_link_if

// file: par_gen.sv
`timescale 1ns/1ps
module par_gen (
   input  wire logic [31:0] ad,
   input  wire logic [3:0]  cbe,
   output logic             par
);
   assign par = ^{ad, cbe};
endmodule : par_gen

// file: pci_target.sv
`timescale 1ns/1ps
module pci_target import pci_pkg::*; #(
   parameter int WAIT_CYC = WAIT_RST
) (
   input  wire logic           clk,
   input  wire logic           nrst,
   pci_link_if.dev             bus,
   input  wire logic [7:0]     irq_src,
   input  wire logic           stop_req,
   output logic [31:0]         wr_data,
   output logic [3:0]          wr_be_n,
   output logic [31:0]         wr_addr,
   output logic                wr_stb,
   output logic [7:0]          irq_pending_reg,
   output logic [7:0]          irq_mask_reg
);
   // The wait counter is four bits wide
   if (WAIT_CYC < 0 || WAIT_CYC > 15) begin : g_bad_wait
      $error("WAIT_CYC out of range");
   end

   typedef enum logic [1:0] {IDLE, DATA, TURN} st_e;

   typedef struct packed {
      st_e         st;
      logic        is_rd;
      logic        is_cfg;
      logic [3:0]  wcnt;
      logic [31:0] addr;
      logic [31:0] iobase;
      logic [31:0] rdata;
      logic        ad_oe;
      logic        par_val;
      logic        par_oe;
      logic        trdy_n;
      logic        stop_n;
      logic        devsel_n;
      logic        tgt_oe;
      logic        inta_oe;
      logic [31:0] wdata;
      logic [3:0]  wbe_n;
      logic [31:0] waddr;
      logic        wstb;
      logic [7:0]  pend;
      logic [7:0]  mask;
      logic        frame_q;
   } st_s;

   st_s s_q, s_d;
   logic [31:0] ad_rd_mux;
   logic        par_calc;
   logic        hit_io, hit_cfg, addr_ph, done;
   logic [31:0] base_wr;

   par_gen par_gen_inst (.ad(s_q.rdata), .cbe(bus.cbe_n), .par(par_calc));

   // Lanes whose enable is high keep the old base byte
   for (genvar b = 0; b < 4; b++) begin : g_lane
      assign base_wr[8*b+:8] = bus.cbe_n[b] ? s_q.iobase[8*b+:8] : bus.ad[8*b+:8];
   end

   always_comb begin
      s_d     = s_q;
      s_d.wstb = 1'b0;
      s_d.frame_q = bus.frame_n;
      // Falling edge of FRAME, so a burst is never taken for an address
      addr_ph = s_q.frame_q && !bus.frame_n && s_q.st == IDLE;
      hit_cfg = bus.idsel && bus.cbe_n[3:1] == CMD_CFG_RD[3:1];
      hit_io  = bus.cbe_n[3:1] == CMD_IO_RD[3:1] &&
                bus.ad[31:IO_SPAN_LOG] == s_q.iobase[31:IO_SPAN_LOG];
      // Nothing completes unless this end is the claimed target
      done    = !s_q.tgt_oe ? 1'b0 : (!bus.irdy_n && !s_q.trdy_n);
      // Read data: status/mask indices answer in either space, else config reads the base and I/O reads status
      case (s_q.addr[7:2])
         CFG_IRQ_IDX: ad_rd_mux = {24'h000000, s_q.pend};
         CFG_MSK_IDX: ad_rd_mux = {24'h000000, s_q.mask};
         default:     ad_rd_mux = s_q.is_cfg ? s_q.iobase : {24'h000000, s_q.pend};
      endcase
      // Parity follows data by one clock, held while data stands
      s_d.par_val = par_calc;
      s_d.par_oe  = s_q.ad_oe;
      s_d.pend = s_q.pend | irq_src;
      case (s_q.st)
         IDLE: begin
            s_d.ad_oe  = 1'b0;
            s_d.tgt_oe = 1'b0;
            if (addr_ph && (hit_cfg || hit_io)) begin
               s_d.st       = DATA;
               s_d.is_rd    = !bus.cbe_n[0];
               s_d.is_cfg   = hit_cfg;
               s_d.addr     = bus.ad;
               s_d.wcnt     = WAIT_CYC[3:0];
               s_d.devsel_n = 1'b0;
               s_d.trdy_n   = 1'b1;
               s_d.stop_n   = 1'b1;
               s_d.tgt_oe   = 1'b1;
            end
         end
         DATA: begin
            if (s_q.is_rd) begin
               s_d.rdata = ad_rd_mux;
               s_d.ad_oe = 1'b1;
            end
            // Fixed wait states before TRDY; a burst reloads them each phase
            if (s_q.wcnt != 4'h0) begin
               s_d.wcnt = s_q.wcnt - 4'h1;
            end else if (s_q.trdy_n) begin
               s_d.trdy_n = 1'b0;
            end
            if (stop_req) s_d.stop_n = 1'b0;
            if (done) begin
               if (!s_q.is_rd) begin
                  s_d.wdata = bus.ad;
                  s_d.wbe_n = bus.cbe_n;
                  s_d.waddr = s_q.addr;
                  s_d.wstb  = 1'b1;
                  if (s_q.is_cfg && s_q.addr[7:2] == CFG_MSK_IDX && !bus.cbe_n[0])
                     s_d.mask = bus.ad[7:0];
                  else if (s_q.is_cfg && s_q.addr[7:2] == CFG_IRQ_IDX && !bus.cbe_n[0])
                     s_d.pend = (s_q.pend & ~bus.ad[7:0]) | irq_src; // Set wins
                  else if (s_q.is_cfg && s_q.addr[7:2] == CFG_BAR_IDX)
                     s_d.iobase = {base_wr[31:IO_SPAN_LOG], {IO_SPAN_LOG{1'b0}}};
               end
               s_d.addr = s_q.addr + 32'h4;
               s_d.wcnt = WAIT_CYC[3:0];
               s_d.trdy_n = WAIT_CYC == 0 ? 1'b0 : 1'b1;
               if (bus.frame_n) begin
                  s_d.st       = TURN;
                  s_d.trdy_n   = 1'b1;
                  s_d.stop_n   = 1'b1;
                  s_d.devsel_n = 1'b1;
                  s_d.ad_oe    = 1'b0;
               end
            end else if (!s_q.stop_n && bus.frame_n && !bus.irdy_n) begin
               // Disconnect with no data: TRDY drops with DEVSEL so no phase completes
               s_d.st = TURN;
               s_d.trdy_n = 1'b1;
               s_d.stop_n = 1'b1;
               s_d.devsel_n = 1'b1;
               s_d.ad_oe = 1'b0;
            end
         end
         TURN: begin
            // One idle clock so both ends never drive a line at once
            s_d.tgt_oe = 1'b0;
            s_d.ad_oe  = 1'b0;
            s_d.st     = IDLE;
         end
         default: s_d.st = IDLE;
      endcase
      // Taken from the next state so a clear or new mask shows at once
      s_d.inta_oe = |(s_d.pend & s_d.mask);
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '{st:       IDLE,
                  iobase:   IO_BASE_RST,
                  mask:     MASK_RST,
                  trdy_n:   1'b1,
                  stop_n:   1'b1,
                  devsel_n: 1'b1,
                  frame_q:  1'b1,
                  default:  '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign bus.ad_d     = s_q.rdata;
   assign bus.ad_d_oe  = s_q.ad_oe;
   assign bus.par_d    = s_q.par_val;
   assign bus.par_d_oe = s_q.par_oe;
   assign bus.trdy_n   = s_q.trdy_n;
   assign bus.stop_n   = s_q.stop_n;
   assign bus.devsel_n = s_q.devsel_n;
   assign bus.tgt_oe   = s_q.tgt_oe;
   assign bus.inta_n_o = 1'b0;
   assign bus.inta_oe  = s_q.inta_oe;
   assign wr_data      = s_q.wdata;
   assign wr_be_n      = s_q.wbe_n;
   assign wr_addr      = s_q.waddr;
   assign wr_stb       = s_q.wstb;
   assign irq_pending_reg = s_q.pend;
   assign irq_mask_reg    = s_q.mask;
endmodule : pci_target

// file: pci_initiator.sv
`timescale 1ns/1ps
module pci_initiator import pci_pkg::*; (
   input  wire logic           clk,
   input  wire logic           nrst,
   pci_link_if.host            bus,
   input  wire logic           req,
   input  wire logic [3:0]     cmd,
   input  wire logic [31:0]    addr,
   input  wire logic [31:0]    wdata,
   input  wire logic [3:0]     be_n,
   output logic                busy,
   output logic                ack,
   output logic [31:0]         rdata,
   output logic                abort,
   output logic                irq
);
   typedef enum logic [1:0] {IDLE, ADDR, DATA, TURN} st_e;
   typedef struct packed {
      st_e         st;
      logic [31:0] ad;
      logic        ad_oe;
      logic [3:0]  cbe;
      logic        par;
      logic        par_oe;
      logic        frame_n;
      logic        irdy_n;
      logic        idsel;
      logic        is_rd;
      logic [3:0]  tmo;
      logic        busy;
      logic        ack;
      logic [31:0] rdata;
      logic        abort;
      logic        irq;
   } st_s;
   st_s s_q, s_d;
   logic par_calc;

   par_gen par_gen_inst (.ad(s_q.ad), .cbe(s_q.cbe), .par(par_calc));

   always_comb begin
      s_d       = s_q;
      s_d.ack   = 1'b0;
      s_d.abort = 1'b0;
      s_d.irq   = !bus.inta_w;
      s_d.par   = par_calc;
      s_d.par_oe = s_q.ad_oe;
      case (s_q.st)
         IDLE: if (req) begin
            s_d.st      = ADDR;
            s_d.frame_n = 1'b0;
            s_d.ad      = addr;
            s_d.ad_oe   = 1'b1;
            s_d.cbe     = cmd;
            // Top address bit stands for a slot other than the target's
            s_d.idsel   = cmd[3:1] == CMD_CFG_RD[3:1] && !addr[31];
            s_d.is_rd   = !cmd[0];
            s_d.busy    = 1'b1;
         end
         ADDR: begin
            s_d.st      = DATA;
            s_d.frame_n = 1'b1;
            s_d.irdy_n  = 1'b0;
            s_d.idsel   = 1'b0;
            s_d.cbe     = be_n;
            s_d.ad      = wdata;
            s_d.ad_oe   = !s_q.is_rd;
            s_d.tmo     = 4'hf;
         end
         DATA: begin
            s_d.tmo = s_q.tmo - 4'h1;
            if (!bus.trdy_w && !s_q.irdy_n) begin
               s_d.rdata = bus.ad;
               s_d.ack   = 1'b1;
               s_d.st    = TURN;
               s_d.irdy_n = 1'b1;
               s_d.ad_oe = 1'b0;
            end else if (!bus.stop_w || (s_q.tmo == 4'h0)) begin
               s_d.abort = 1'b1;
               s_d.st    = TURN;
               s_d.irdy_n = 1'b1;
               s_d.ad_oe = 1'b0;
            end
         end
         TURN: begin
            s_d.st   = IDLE;
            s_d.busy = 1'b0;
         end
         default: s_d.st = IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) s_q <= '{st: IDLE, frame_n: 1'b1, irdy_n: 1'b1, cbe: 4'hf, default: '0};
      else       s_q <= s_d;
   end

   assign bus.ad_h     = s_q.ad;
   assign bus.ad_h_oe  = s_q.ad_oe;
   assign bus.cbe_n    = s_q.cbe;
   assign bus.par_h    = s_q.par;
   assign bus.par_h_oe = s_q.par_oe;
   assign bus.frame_n  = s_q.frame_n;
   assign bus.irdy_n   = s_q.irdy_n;
   assign bus.idsel    = s_q.idsel;
   assign busy         = s_q.busy;
   assign ack          = s_q.ack;
   assign rdata        = s_q.rdata;
   assign abort        = s_q.abort;
   assign irq          = s_q.irq;
endmodule : pci_initiator

// file: pci_monitor.sv
`timescale 1ns/1ps
module pci_monitor import pci_pkg::*; (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic [31:0] ad,
   input wire logic        ad_h_oe,
   input wire logic        ad_d_oe,
   input wire logic [3:0]  cbe_n,
   input wire logic        par,
   input wire logic        par_d_oe,
   input wire logic        frame_n,
   input wire logic        irdy_n,
   input wire logic        idsel,
   input wire logic        trdy_w,
   input wire logic        stop_w,
   input wire logic        devsel_w
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_par_even:
      assert property (par_d_oe |-> par == ^{$past(ad), $past(cbe_n)}) else $error("bad parity");
   chk_par_source:
      assert property (par_d_oe |-> $past(ad_d_oe)) else $error("parity without read data");
   chk_ad_contention:
      assert property (!(ad_h_oe && ad_d_oe)) else $error("both ends drive AD");
   chk_trdy_read_data:
      assert property (!trdy_w && !ad_h_oe |-> ad_d_oe) else $error("read ready without data");
   chk_par_after_phase:
      assert property (!irdy_n && !trdy_w && ad_d_oe |=> par_d_oe) else $error("parity dropped");
   chk_last_phase_end:
      assert property (!irdy_n && !trdy_w && frame_n |=> trdy_w) else $error("ready after last");
   chk_io_claim:
      assert property ($fell(frame_n) && cbe_n[3:1] == 3'b001 && ad[31:5] == IO_BASE_RST[31:5]
         |=> !devsel_w) else $error("own io address not claimed");
   chk_cfg_no_idsel:
      assert property ($fell(frame_n) && cbe_n[3:1] == 3'b101 && !idsel |=> devsel_w [*2])
         else $error("config claimed without select");
   chk_stop_claimed:
      assert property (!stop_w |-> !devsel_w) else $error("stop while not claimed");
   chk_release_lines:
      assert property (devsel_w && $past(devsel_w) |-> !ad_d_oe && !par_d_oe)
         else $error("lines driven while not selected");
   cover property (!irdy_n && !trdy_w && ad_d_oe);
   cover property (!irdy_n && !trdy_w && ad_h_oe);
   cover property (!stop_w);
endmodule : pci_monitor

// file: test_pci_target_interface.sv
`timescale 1ns/1ps
module test_pci_target_interface import pci_pkg::*; ;
   logic        clk, nrst, req, stop_req, ab;
   logic [3:0]  cmd, be_n, got_be;
   logic [31:0] addr, wdata, got_d, got_a, rd;
   logic [7:0]  irq_src;
   wire         busy, ack, abort, irq, wr_stb;
   wire  [31:0] rdata, wr_data, wr_addr;
   wire  [3:0]  wr_be_n;
   wire  [7:0]  irq_pending_reg, irq_mask_reg;
   int          n_fail, cmp_count, cyc;
   pci_link_if link();
   pci_target pci_target_inst (.clk(clk), .nrst(nrst), .bus(link), .irq_src(irq_src),
      .stop_req(stop_req), .wr_data(wr_data), .wr_be_n(wr_be_n), .wr_addr(wr_addr),
      .wr_stb(wr_stb), .irq_pending_reg(irq_pending_reg), .irq_mask_reg(irq_mask_reg));
   pci_initiator pci_initiator_inst (.clk(clk), .nrst(nrst), .bus(link), .req(req), .cmd(cmd),
      .addr(addr), .wdata(wdata), .be_n(be_n), .busy(busy), .ack(ack), .rdata(rdata),
      .abort(abort), .irq(irq));
   pci_monitor pci_monitor_inst (.clk(clk), .nrst(nrst), .ad(link.ad), .ad_h_oe(link.ad_h_oe),
      .ad_d_oe(link.ad_d_oe), .cbe_n(link.cbe_n), .par(link.par), .par_d_oe(link.par_d_oe),
      .frame_n(link.frame_n), .irdy_n(link.irdy_n), .idsel(link.idsel), .trdy_w(link.trdy_w),
      .stop_w(link.stop_w), .devsel_w(link.devsel_w));
   initial clk = 1'b0;
   always #50 clk = ~clk;
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic test_done();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : test_done
   // Timeout guards against a target that never answers
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         n_fail++;
         test_done();
      end
   end
   always @(posedge clk) begin
      if (wr_stb === 1'b1) begin
         got_d <= wr_data;
         got_be <= wr_be_n;
         got_a <= wr_addr;
      end
   end
   task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      #1;
      req = 1'b1;
      cmd = c;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1;
      req = 1'b0;
      n = 0;
      while (ack !== 1'b1 && abort !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      rd = rdata;
      ab = abort;
      while (busy !== 1'b0 && n < 60) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask : xfer
   task automatic t_io_write();
      be_n = 4'h9;
      xfer(CMD_IO_WR, IO_BASE_RST + 32'h8, 32'h1122_3344);
      check("wr abort", {31'h0, ab}, 32'h0);
      check("wr data", got_d, 32'h1122_3344);
      check("wr be", {28'h0, got_be}, 32'h9);
      check("wr addr", got_a, IO_BASE_RST + 32'h8);
   endtask : t_io_write
   task automatic t_cmds();
      be_n = 4'h0;
      for (int i = 0; i < 16; i++) begin
         if (i != 10 && i != 11) begin
            xfer(i[3:0], IO_BASE_RST, 32'h0);
            check("cmd abort", {31'h0, ab}, {31'h0, !(i == 2 || i == 3)});
         end
      end
      xfer(CMD_CFG_RD, 32'h8000_00f8, 32'h0);
      check("cfg no idsel", {31'h0, ab}, 32'h1);
   endtask : t_cmds
   task automatic t_stop();
      stop_req = 1'b1;
      xfer(CMD_IO_RD, IO_BASE_RST, 32'h0);
      check("stop abort", {31'h0, ab}, 32'h1);
      stop_req = 1'b0;
   endtask : t_stop
   task automatic t_irq();
      irq_src = 8'h04;
      @(posedge clk);
      #1;
      irq_src = 8'h00;
      xfer(CMD_IO_RD, IO_BASE_RST, 32'h0);
      check("pending rd", {24'h0, rd[7:0]}, 32'h4);
      check("masked irq", {31'h0, irq}, 32'h0);
      xfer(CMD_CFG_WR, 32'h0000_00f8, 32'h4);
      xfer(CMD_CFG_RD, 32'h0000_00f8, 32'h0);
      check("mask rd", {24'h0, rd[7:0]}, 32'h4);
      check("mask reg", {24'h0, irq_mask_reg}, 32'h4);
      check("irq on", {31'h0, irq}, 32'h1);
      xfer(CMD_CFG_WR, 32'h0000_00fc, 32'h4);
      xfer(CMD_IO_RD, IO_BASE_RST, 32'h0);
      check("pending clr", {24'h0, irq_pending_reg}, 32'h0);
      check("irq off", {31'h0, irq}, 32'h0);
   endtask : t_irq
   task automatic t_base();
      be_n = 4'hd;
      xfer(CMD_CFG_WR, 32'h0000_0010, 32'h1200_0400);
      xfer(CMD_CFG_RD, 32'h0000_0010, 32'h0);
      check("base rd", rd, 32'h0000_0400);
      xfer(CMD_IO_WR, 32'h0000_0404, 32'h0000_0055);
      check("base abort", {31'h0, ab}, 32'h0);
      check("base addr", got_a, 32'h0000_0404);
      xfer(CMD_CFG_WR, 32'h0000_0010, IO_BASE_RST);
      xfer(CMD_IO_RD, IO_BASE_RST, 32'h0);
      check("base back", {31'h0, ab}, 32'h0);
   endtask : t_base
   initial begin
      nrst = 1'b0;
      req = 1'b0;
      stop_req = 1'b0;
      cmd = 4'h0;
      addr = 32'h0;
      wdata = 32'h0;
      be_n = 4'h0;
      irq_src = 8'h00;
      repeat (6) @(posedge clk);
      #1;
      nrst = 1'b1;
      t_io_write();
      t_cmds();
      t_stop();
      t_irq();
      t_base();
      test_done();
   end
endmodule : test_pci_target_interface
